/* File: adc_compute_defs.vh */
// Register offsets, field positions and counts of the ADC result computation unit
`ifndef ADC_COMPUTE_DEFS_VH
`define ADC_COMPUTE_DEFS_VH
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_REPEAT 8'h08
`define OFS_COUNT 8'h0C
`define OFS_ACC 8'h10
`define OFS_FILTER 8'h14
`define OFS_RESULT 8'h18
`define OFS_THRESH 8'h1C
`define CTRL_MODE_LSB 0
`define CTRL_DSEN_BIT 3
`define CTRL_SHIFT_LSB 4
`define CTRL_CLR_BIT 7
`define CTRL_GO_BIT 8
`define CTRL_RC_BIT 9
`define CTRL_CAP_BIT 10
`define CTRL_TMODE_LSB 11
`define ST_DONE_BIT 0
`define ST_THR_BIT 1
`define ST_OVF_BIT 2
`define MODE_BASIC 3'h0
`define MODE_ACCUM 3'h1
`define MODE_AVERAGE 3'h2
`define MODE_BURST 3'h3
`define MODE_LPF 3'h4
`define TM_NEVER 3'h0
`define TM_LT_LOW 3'h1
`define TM_GE_LOW 3'h2
`define TM_INSIDE 3'h3
`define TM_OUTSIDE 3'h4
`define TM_LE_UP 3'h5
`define TM_GT_UP 3'h6
`define TM_ALWAYS 3'h7
`define CNT_MAX 8'hFF
`define CLEAR_RC_TICKS 3'h5
`define RC_DIV_DEFAULT 100
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: adc_compute_unit.v */
// ADC post-conversion computation unit with AXI4-Lite register access
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "adc_compute_defs.vh"
// How it works
// RULE_01: Three-bit mode field picks computation behaviour
// RULE_02: Basic mode: no accumulation, test every sample
// RULE_03: Accumulate adds sample, counter saturates at FF
// RULE_04: Accumulate sets threshold and done flags
// RULE_05: Average tests at target, clears next trigger
// RULE_06: Burst clears on go, retriggers until target
// RULE_07: Filter: sample plus acc minus shifted acc
// RULE_08: Double sample uses difference over two conversions
// RULE_09: Sixteen-bit accumulator, overflow above 65535
// RULE_10: Each trigger adds result and counts sample; the code does so per completed conversion, not per trigger
// RULE_11: Clear bit clears acc, overflow, counter, itself
// RULE_12: RC clock clear takes five RC cycles
// RULE_13: Filter output is accumulator shifted right
// RULE_14: Shift 1 to 6 sets filter cutoff
// RULE_15: Extra hold capacitance only while sampling
// RULE_16: Met threshold condition sets threshold flag
// RULE_17: Overflow signals threshold; comparisons are signed
// RULE_18: Result zero-extended, difference sign-extended
module adc_compute_unit #(
  parameter RES_W = 10,
  parameter RC_DIV = `RC_DIV_DEFAULT
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire ext_trigger,
  input wire conv_done,
  input wire [RES_W-1:0] conversion_result,
  input wire sampling,
  output reg conv_start_r,
  output reg extra_hold_capacitance_r
);
  // Control fields
  reg [2:0] compute_mode_select;
  reg double_sample_enable;
  reg [2:0] shift_amount;
  reg conversion_go;
  reg use_internal_rc_clock;
  reg extra_cap_enable;
  reg [2:0] thresh_mode;
  reg [7:0] repeat_target;
  reg [15:0] lower_thresh;
  reg [15:0] upper_thresh;
  // State
  reg [15:0] sum_accumulator;
  reg [7:0] sample_counter;
  reg sum_overflow_flag;
  reg conversion_done_flag;
  reg threshold_hit_flag;
  reg [RES_W-1:0] result_r;
  reg [RES_W-1:0] previous_result;
  reg second_half_r;
  // AXI holding registers
  reg [7:0] aw_addr_r;
  reg aw_have_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg w_have_r;

  wire clr_busy;
  wire clr_done;
  wire do_write;
  wire clr_start;
  wire go_write;
  wire trigger;
  wire [15:0] filter_output;
  wire signed [17:0] sample_term;
  wire signed [17:0] acc_sum;
  wire step;
  wire [7:0] cnt_next;
  wire test_due;
  wire thr_met;
  wire [1:0] unused_prot;
  wire signed [15:0] err_val;

  assign unused_prot = s_axi_awprot[1:0] ^ s_axi_arprot[1:0];

  function thresh_check;
    input [2:0] mode;
    input signed [15:0] err;
    input signed [15:0] lo;
    input signed [15:0] hi;
    begin
      case (mode)
        `TM_NEVER: thresh_check = 1'b0;
        `TM_LT_LOW: thresh_check = (err < lo);
        `TM_GE_LOW: thresh_check = (err >= lo);
        `TM_INSIDE: thresh_check = (err >= lo) && (err <= hi);
        `TM_OUTSIDE: thresh_check = (err < lo) || (err > hi);
        `TM_LE_UP: thresh_check = (err <= hi);
        `TM_GT_UP: thresh_check = (err > hi);
        default: thresh_check = 1'b1;
      endcase
    end
  endfunction

  function [31:0] merge_bytes;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        merge_bytes[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  sum_clear_seq #(
    .RC_DIV(RC_DIV)
  ) u_clear (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(clr_start),
    .use_rc(use_internal_rc_clock),
    .busy_r(clr_busy),
    .done_r(clr_done)
  );

  assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
  wire [31:0] ctrl_word = {18'h00000, thresh_mode, extra_cap_enable, use_internal_rc_clock,
    conversion_go, clr_busy, shift_amount, double_sample_enable, compute_mode_select};
  wire [31:0] ctrl_new = merge_bytes(ctrl_word, w_data_r, w_strb_r);
  wire ctrl_wr = do_write && (aw_addr_r == `OFS_CTRL);
  assign clr_start = ctrl_wr && ctrl_new[`CTRL_CLR_BIT] && !clr_busy; // see RULE_11
  assign go_write = ctrl_wr && ctrl_new[`CTRL_GO_BIT] && !conversion_go;
  assign trigger = go_write || ext_trigger;

  // Low-pass and average outputs both scale the accumulator by the shift field
  assign filter_output = sum_accumulator >> shift_amount; // see RULE_13 see RULE_14
  // A difference can be negative, so the term is carried signed
  assign sample_term = double_sample_enable ?
    ($signed({8'h00, conversion_result}) - $signed({8'h00, previous_result})) :
    $signed({8'h00, conversion_result}); // see RULE_08 see RULE_18
  assign acc_sum = (compute_mode_select == `MODE_LPF) ?
    ($signed({2'b00, sum_accumulator}) + sample_term - $signed({2'b00, filter_output})) :
    ($signed({2'b00, sum_accumulator}) + sample_term); // see RULE_07 see RULE_10
  // In double sample mode only the second conversion completes a cycle
  assign step = conv_done && !clr_busy && (!double_sample_enable || second_half_r);
  assign cnt_next = (sample_counter == `CNT_MAX) ? sample_counter :
    sample_counter + 8'h01; // see RULE_03
  assign test_due = (compute_mode_select == `MODE_BASIC) ||
    (compute_mode_select == `MODE_ACCUM) || (cnt_next >= repeat_target); // see RULE_05
  // The test must see the accumulator after this sample is folded in, not before
  assign err_val = (compute_mode_select == `MODE_BASIC) ? sample_term[15:0] :
    (acc_sum[15:0] >> shift_amount); // see RULE_16
  assign thr_met = thresh_check(thresh_mode, err_val, lower_thresh, upper_thresh) ||
    sum_overflow_flag || (acc_sum > 18'sd65535); // see RULE_17

  // Computation datapath
  always @(posedge aclk) begin
    if (!aresetn) begin
      sum_accumulator <= 16'h0000;
      sample_counter <= 8'h00;
      sum_overflow_flag <= 1'b0;
      result_r <= {RES_W{1'b0}};
      previous_result <= {RES_W{1'b0}};
      second_half_r <= 1'b0;
    end else if (clr_done) begin
      sum_accumulator <= 16'h0000; // see RULE_11
      sample_counter <= 8'h00;
      sum_overflow_flag <= 1'b0;
    end else begin
      if (trigger && ((compute_mode_select == `MODE_BURST) ||
          ((compute_mode_select == `MODE_AVERAGE) && (sample_counter >= repeat_target)))) begin
        sum_accumulator <= 16'h0000; // see RULE_05 see RULE_06
        sample_counter <= 8'h00;
      end
      if (conv_done && !clr_busy) begin
        result_r <= conversion_result;
        if (double_sample_enable) begin
          second_half_r <= !second_half_r;
          if (!second_half_r) begin
            previous_result <= conversion_result;
          end
        end else begin
          second_half_r <= 1'b0;
          previous_result <= result_r;
        end
      end
      if (step && (compute_mode_select != `MODE_BASIC) &&
          (compute_mode_select <= `MODE_LPF)) begin // see RULE_01 see RULE_02
        sum_accumulator <= acc_sum[15:0]; // see RULE_09
        sample_counter <= cnt_next;
        if (acc_sum > 18'sd65535) begin
          sum_overflow_flag <= 1'b1;
        end
      end
    end
  end

  // Flags, go bit and retrigger; a hardware set wins over a software clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      conversion_done_flag <= 1'b0;
      threshold_hit_flag <= 1'b0;
      conversion_go <= 1'b0;
      conv_start_r <= 1'b0;
      extra_hold_capacitance_r <= 1'b0;
    end else begin
      conv_start_r <= 1'b0;
      extra_hold_capacitance_r <= extra_cap_enable && sampling; // see RULE_15
      if (do_write && (aw_addr_r == `OFS_STATUS) && w_strb_r[0]) begin
        if (w_data_r[`ST_DONE_BIT]) begin
          conversion_done_flag <= 1'b0;
        end
        if (w_data_r[`ST_THR_BIT]) begin
          threshold_hit_flag <= 1'b0;
        end
      end
      if (conv_done && !clr_busy) begin
        conversion_done_flag <= 1'b1; // see RULE_02 see RULE_04
      end
      if (step && test_due && thr_met && (compute_mode_select <= `MODE_LPF)) begin
        threshold_hit_flag <= 1'b1; // see RULE_04 see RULE_16
      end
      if (go_write) begin
        conversion_go <= 1'b1;
        conv_start_r <= 1'b1;
      end else if (step && (compute_mode_select == `MODE_BURST) &&
          (cnt_next < repeat_target)) begin
        conv_start_r <= 1'b1; // see RULE_06
      end else if (conv_done && double_sample_enable && !second_half_r) begin
        conv_start_r <= conversion_go;
      end else if (conv_done) begin
        conversion_go <= 1'b0;
      end
    end
  end

  // Register writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      compute_mode_select <= `MODE_BASIC;
      double_sample_enable <= 1'b0;
      shift_amount <= 3'h0;
      use_internal_rc_clock <= 1'b0;
      extra_cap_enable <= 1'b0;
      thresh_mode <= `TM_NEVER;
      repeat_target <= 8'h00;
      lower_thresh <= 16'h0000;
      upper_thresh <= 16'h0000;
    end else if (do_write) begin
      if (aw_addr_r == `OFS_CTRL) begin
        compute_mode_select <= ctrl_new[`CTRL_MODE_LSB +: 3];
        double_sample_enable <= ctrl_new[`CTRL_DSEN_BIT];
        shift_amount <= ctrl_new[`CTRL_SHIFT_LSB +: 3];
        use_internal_rc_clock <= ctrl_new[`CTRL_RC_BIT];
        extra_cap_enable <= ctrl_new[`CTRL_CAP_BIT];
        thresh_mode <= ctrl_new[`CTRL_TMODE_LSB +: 3];
      end
      if ((aw_addr_r == `OFS_REPEAT) && w_strb_r[0]) begin
        repeat_target <= w_data_r[7:0];
      end
      if (aw_addr_r == `OFS_THRESH) begin
        {upper_thresh, lower_thresh} <= merge_bytes({upper_thresh, lower_thresh},
          w_data_r, w_strb_r);
      end
    end
  end

  // AXI4-Lite write channels: address and data taken independently
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r == `OFS_CTRL || aw_addr_r == `OFS_STATUS ||
          aw_addr_r == `OFS_REPEAT || aw_addr_r == `OFS_THRESH) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'b00})
          `OFS_CTRL: s_axi_rdata <= ctrl_word;
          `OFS_STATUS: s_axi_rdata <= {29'h00000000, sum_overflow_flag,
            threshold_hit_flag, conversion_done_flag};
          `OFS_REPEAT: s_axi_rdata <= {24'h000000, repeat_target};
          `OFS_COUNT: s_axi_rdata <= {24'h000000, sample_counter};
          `OFS_ACC: s_axi_rdata <= {16'h0000, sum_accumulator};
          `OFS_FILTER: s_axi_rdata <= {16'h0000, filter_output};
          `OFS_RESULT: s_axi_rdata <= {{(16-RES_W){1'b0}}, previous_result,
            {(16-RES_W){1'b0}}, result_r};
          `OFS_THRESH: s_axi_rdata <= {upper_thresh, lower_thresh};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // adc_compute_unit
`default_nettype wire

/* File: adc_compute_unit_properties.sv */
// Port-level checks of the ADC computation unit
`timescale 1ns/1ps
`default_nettype none
module adc_compute_checks (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic conv_done,
  input wire logic sampling,
  input wire logic conv_start_r,
  input wire logic extra_hold_capacitance_r
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_cap_samp;
    extra_hold_capacitance_r |-> $past(sampling);
  endproperty
  a_cap_samp: assert property (p_cap_samp) else $error("cap on outside sampling");
  property p_cap_conv;
    !sampling [*2] |-> !extra_hold_capacitance_r;
  endproperty
  a_cap_conv: assert property (p_cap_conv) else $error("cap on in conversion");
  // A start needs a go write or, in burst or after the first double-sample conversion, the previous end of conversion
  property p_start_cause;
    conv_start_r |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(conv_done)
      || $past(conv_done, 2);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without cause");
  property p_start_pulse;
    conv_start_r |=> !conv_start_r;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
  property p_wr_resp;
    s_axi_awvalid && s_axi_wvalid |-> ##[1:6] s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_once: assert property (p_b_once) else $error("write response repeated");
  property p_rd_resp;
    s_axi_arvalid |-> ##[1:6] s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("no read response");
  property p_r_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_once: assert property (p_r_once) else $error("read response repeated");
endmodule // adc_compute_checks
bind adc_compute_unit adc_compute_checks i_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .conv_done(conv_done), .sampling(sampling),
  .conv_start_r(conv_start_r), .extra_hold_capacitance_r(extra_hold_capacitance_r));
`default_nettype wire

/* File: conv_core_model.sv */
// Behavioural conversion core: sample, convert, then one done pulse
`timescale 1ns/1ps
`default_nettype none
module conv_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [3:0] lat,
  input wire logic [9:0] value,
  output logic conv_done,
  output logic [9:0] result,
  output logic sampling
);
  logic [3:0] cnt_r;
  always @(posedge aclk) begin
    conv_done <= 1'b0;
    // Result is only valid with the done pulse, so it toggles otherwise
    result <= ~result;
    if (!aresetn) begin
      cnt_r <= 4'h0;
      sampling <= 1'b0;
      result <= 10'h155;
    end else if (start && cnt_r == 4'h0) begin
      cnt_r <= lat;
      sampling <= 1'b1;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
      if (cnt_r == 4'h2) sampling <= 1'b0;
      if (cnt_r == 4'h1) begin
        conv_done <= 1'b1;
        result <= value;
      end
    end
  end
endmodule // conv_core_model
`default_nettype wire

/* File: sum_clear_seq.v */
// Accumulator clear sequencer, timed by system clock or internal RC clock enable
`timescale 1ns/1ps
`default_nettype none
`include "adc_compute_defs.vh"
module sum_clear_seq #(
  parameter RC_DIV = `RC_DIV_DEFAULT
) (
  input wire aclk,
  input wire aresetn,
  input wire start,
  input wire use_rc,
  output reg busy_r,
  output reg done_r
);
  reg [15:0] div_r;
  reg [2:0] ticks_r;
  wire rc_tick;
  // Stand-in for the internal RC clock: one-cycle enable from a divider
  assign rc_tick = (div_r == 16'h0000);
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 16'h0000;
    end else if (rc_tick) begin
      div_r <= RC_DIV[15:0] - 16'h0001;
    end else begin
      div_r <= div_r - 16'h0001;
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      ticks_r <= 3'h0;
    end else begin
      done_r <= 1'b0;
      if (!busy_r) begin
        if (start) begin
          busy_r <= 1'b1;
          ticks_r <= 3'h0;
        end
      end else if (!use_rc) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end else if (rc_tick) begin
        if (ticks_r == `CLEAR_RC_TICKS - 3'h1) begin // see RULE_12
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          ticks_r <= ticks_r + 3'h1;
        end
      end
    end
  end
endmodule // sum_clear_seq
`default_nettype wire

/* File: test_adc_result_computation_unit.sv */
// Self-checking bench of the ADC result computation unit
`timescale 1ns/1ps
`default_nettype none
`include "adc_compute_defs.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module test_adc_result_computation_unit;
  localparam int RC_DIV = 4;
  localparam logic [31:0] CLR = 32'h80;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic ext_trg = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, start, cap, done, samp;
  logic [1:0] bresp, rresp;
  logic [9:0] res, value = 10'h000;
  logic [3:0] lat = 4'h3;
  int fails = 0, checked = 0, cyc = 0, t;
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  adc_compute_unit #(.RES_W(10), .RC_DIV(RC_DIV)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_trigger(ext_trg), .conv_done(done), .conversion_result(res), .sampling(samp),
    .conv_start_r(start), .extra_hold_capacitance_r(cap));
  conv_core_model i_core (.aclk(aclk), .aresetn(aresetn), .start(start | ext_trg),
    .lat(lat), .value(value), .conv_done(done), .result(res), .sampling(samp));
  task automatic final_report();
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic give_up();
    fails++;
    final_report();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 64);
    bready <= 1'b0;
    if (n >= 64) give_up();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 64);
    v = rdata;
    rready <= 1'b0;
    if (n >= 64) give_up();
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, d);
    `CHK(d, e);
  endtask
  // External trigger; the core model answers after its latency
  task automatic conv(input logic [9:0] v);
    int n = 0;
    @(posedge aclk);
    value <= v;
    ext_trg <= 1'b1;
    @(posedge aclk);
    ext_trg <= 1'b0;
    while (!done && n < 40) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 40) give_up();
    repeat (2) @(posedge aclk);
  endtask
  task automatic clr(input logic [31:0] c);
    int n = 0;
    wr(`OFS_CTRL, c | CLR);
    t = cyc;
    do begin
      rd(`OFS_CTRL, d);
      n++;
    end while (d[`CTRL_CLR_BIT] && n < 200);
    t = cyc - t;
    if (n >= 200) give_up();
  endtask
  task automatic t_accum();
    wr(`OFS_CTRL, 32'h421);
    conv(10'h3FF);
    conv(10'h3FF);
    conv(10'h1F4);
    rc(`OFS_ACC, 32'h9F2);
    rc(`OFS_COUNT, 32'h3);
    rc(`OFS_FILTER, 32'h27C);
    rc(`OFS_STATUS, 32'h1);
    for (int i = 0; i < 263; i++) conv(i < 63 ? 10'h3FF : 10'h000);
    rc(`OFS_ACC, 32'h5B3);
    rc(`OFS_COUNT, 32'hFF);
    rc(`OFS_STATUS, 32'h7);
    wr(8'h20, CLR);
    `CHK(bresp, `RESP_SLVERR);
    rc(`OFS_COUNT, 32'hFF);
    rd(8'h20, d);
    `CHK(rresp, `RESP_SLVERR);
    `CHK(d, 32'h0);
  endtask
  task automatic t_clear();
    clr(32'h201);
    `CHK(t >= 4 * RC_DIV - 1, 1'b1);
    rc(`OFS_ACC, 32'h0);
    rc(`OFS_COUNT, 32'h0);
    rd(`OFS_STATUS, d);
    `CHK(d[`ST_OVF_BIT], 1'b0);
  endtask
  task automatic t_basic();
    wr(`OFS_CTRL, 32'h3800);
    wr(`OFS_STATUS, 32'h3);
    conv(10'h025);
    rc(`OFS_ACC, 32'h0);
    rc(`OFS_COUNT, 32'h0);
    rc(`OFS_STATUS, 32'h3);
  endtask
  task automatic t_avg();
    wr(`OFS_REPEAT, 32'h2);
    clr(32'h3802);
    wr(`OFS_STATUS, 32'h3);
    conv(10'h00A);
    rc(`OFS_STATUS, 32'h1);
    conv(10'h014);
    rc(`OFS_STATUS, 32'h3);
    rc(`OFS_ACC, 32'h1E);
    conv(10'h005);
    rc(`OFS_ACC, 32'h5);
    rc(`OFS_COUNT, 32'h1);
  endtask
  // Slow core: the unit must keep retriggering on its own until the target
  task automatic t_burst();
    int n;
    lat <= 4'h9;
    wr(`OFS_REPEAT, 32'h3);
    clr(32'h3803);
    for (int k = 0; k < 2; k++) begin
      value <= (k == 0) ? 10'h007 : 10'h004;
      wr(`OFS_CTRL, 32'h3903);
      n = 0;
      do begin
        rd(`OFS_COUNT, d);
        n++;
      end while (d !== 32'h3 && n < 40);
      if (n >= 40) give_up();
      repeat (40) @(posedge aclk);
      rc(`OFS_ACC, (k == 0) ? 32'h15 : 32'hC);
      rc(`OFS_COUNT, 32'h3);
    end
    lat <= 4'h3;
  endtask
  // Window test on the filter output once the repeat target is reached
  task automatic t_lpf();
    wr(`OFS_THRESH, 32'h00640032);
    `CHK(bresp, `RESP_OKAY);
    clr(32'h1814);
    wr(`OFS_STATUS, 32'h3);
    conv(10'h064);
    conv(10'h064);
    rd(`OFS_STATUS, d);
    `CHK(d[`ST_THR_BIT], 1'b0);
    conv(10'h028);
    rc(`OFS_ACC, 32'h73);
    rd(`OFS_STATUS, d);
    `CHK(d[`ST_THR_BIT], 1'b1);
  endtask
  task automatic t_dsample();
    wr(`OFS_THRESH, 32'h0000FFFB);
    clr(32'h809);
    wr(`OFS_STATUS, 32'h3);
    conv(10'h12C);
    rd(`OFS_STATUS, d);
    `CHK(d[`ST_THR_BIT], 1'b0);
    conv(10'h064);
    rc(`OFS_ACC, 32'hFF38);
    rc(`OFS_COUNT, 32'h1);
    rd(`OFS_STATUS, d);
    `CHK(d[`ST_THR_BIT], 1'b1);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_accum();
    t_clear();
    t_basic();
    t_avg();
    t_burst();
    t_lpf();
    t_dsample();
    final_report();
  end
endmodule // test_adc_result_computation_unit
`default_nettype wire
